// ---- src/sps_sideband_port_sync.sv ----
// Top of the sideband port synchronizer: locks the sideband phase on the
// sync pattern, moves strobe-latched words into the base clock domain and
// marks the first transfer clock on the main bus.
// Assumes the master follows the sync, no-op padding and stop sequence.
`timescale 1ns/100ps
module sps_sideband_port_sync
    import sps_pkg::*;
(
    // Base clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Sideband strobe domain
    input  wire logic       sideband_strobe,
    input  wire logic [7:0] sideband_address_lines,
    // Mode from local configuration logic
    input  wire logic       quad_mode,
    // Main bus handshake pin
    input  wire logic       transfer_ready_handshake_n,
    // Sideband command output
    output sps_cmd_t        cmd_out,
    output logic            sync_locked,
    output logic            stop_short_err,
    // Main bus phase markers
    output logic            ad_first_transfer_clock,
    output logic            ad_second_transfer_clock
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    sps_ring_t              ring;
    logic       [PTR_W-1:0] wr_gray;
    logic       [PTR_W-1:0] wr_gray_sync;
    logic       [7:0]       lines_sync;
    logic                   ready_n_sync;

    sps_state_t             state_ff;
    sps_state_t             nxt_state;
    logic       [1:0]       wait_cnt_ff;
    logic       [PTR_W-1:0] rd_ptr_ff;
    logic       [PTR_W-1:0] gray_seen_ff;
    logic       [2:0]       still_cnt_ff;
    logic       [3:0]       stop_cnt_ff;
    logic                   strobe_stopped;
    logic                   sync_seen;
    sps_cmd_t               cmd_ff;
    logic                   locked_ff;
    logic                   stop_err_ff;
    logic                   ad_t1_ff;
    logic                   ad_t2_ff;

    // -------------------------------------------------------------------
    // Strobe-domain capture and crossings
    // -------------------------------------------------------------------
    sps_strobe_capture u_capture (
        .strobe_clk             (sideband_strobe),
        .srst                   (srst),
        .sideband_address_lines (sideband_address_lines),
        .ring                   (ring),
        .wr_gray                (wr_gray)
    );

    sps_sync2 #(.W(PTR_W)) u_ptr_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (wr_gray),
        .sync_out (wr_gray_sync)
    );

    sps_sync2 #(.W(8)) u_lines_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (sideband_address_lines),
        .sync_out (lines_sync)
    );

    sps_sync2 #(.W(1), .RESET_VAL(READY_N_IDLE)) u_ready_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (transfer_ready_handshake_n),
        .sync_out (ready_n_sync)
    );

    // -------------------------------------------------------------------
    // Sync pattern detection on base-rate samples
    // -------------------------------------------------------------------
    // Only the unlocked state looks at the base-rate samples, so lines
    // during the wait and run states are still synchronised every clock but never acted on.
    assign sync_seen = (state_ff == SS_UNLOCKED) &&
                       is_sync_pattern(lines_sync);

    // -------------------------------------------------------------------
    // Strobe stop detection
    // -------------------------------------------------------------------
    // Activity is judged from the synchronised write pointer only; the
    // strobe itself is never sampled by the base clock.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gray_seen_ff <= PTR_RESET;
            still_cnt_ff <= '0;
        end
        else
        begin
            gray_seen_ff <= wr_gray_sync;
            if (wr_gray_sync != gray_seen_ff || state_ff != SS_RUN)
            begin
                still_cnt_ff <= '0;
            end
            else if (still_cnt_ff != STOP_DETECT_CLKS)
            begin
                still_cnt_ff <= still_cnt_ff + 3'h1;
            end
        end
    end

    assign strobe_stopped = (still_cnt_ff == STOP_DETECT_CLKS);

    // -------------------------------------------------------------------
    // Stopped-time check before a new sync
    // -------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stop_cnt_ff <= STOP_MIN_CLKS;
            stop_err_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == SS_RUN && strobe_stopped)
            begin
                stop_cnt_ff <= STOP_CNT_RESET + 4'(STOP_DETECT_CLKS);
            end
            else if (state_ff == SS_UNLOCKED && stop_cnt_ff != STOP_MIN_CLKS)
            begin
                stop_cnt_ff <= stop_cnt_ff + 4'h1;
            end
            if (sync_seen && stop_cnt_ff != STOP_MIN_CLKS)
            begin
                stop_err_ff <= 1'b1;
            end
            else if (sync_seen)
            begin
                stop_err_ff <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Lock state machine
    // -------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SS_UNLOCKED:
            begin
                if (sync_seen)
                begin
                    nxt_state = SS_WAIT;
                end
            end
            SS_WAIT:
            begin
                if (wait_cnt_ff == '0)
                begin
                    nxt_state = SS_RUN;
                end
            end
            SS_RUN:
            begin
                if (strobe_stopped)
                begin
                    nxt_state = SS_UNLOCKED;
                end
            end
            default:
            begin
                nxt_state = SS_UNLOCKED;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= SS_UNLOCKED;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // -------------------------------------------------------------------
    // Wait count from sync to the first transfer clock
    // -------------------------------------------------------------------
    // The pattern is seen one clock after it was sampled; the first
    // transfer clock then opens after one more clock, and its data is
    // safe at the end of the second transfer clock.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wait_cnt_ff <= '0;
        end
        else if (sync_seen)
        begin
            wait_cnt_ff <= WAIT_LOAD;
        end
        else if (state_ff == SS_WAIT && wait_cnt_ff != '0)
        begin
            wait_cnt_ff <= wait_cnt_ff - 2'h1;
        end
    end

    // -------------------------------------------------------------------
    // Read pointer, aligned to the writer at the sync
    // -------------------------------------------------------------------
    // The writer is idle around the sync, so its synchronised pointer
    // names the slot that the first strobed word will land in.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_ptr_ff <= PTR_RESET;
        end
        else if (sync_seen)
        begin
            rd_ptr_ff <= gray2bin(wr_gray_sync);
        end
        else if (state_ff == SS_RUN)
        begin
            rd_ptr_ff <= rd_ptr_ff + (quad_mode ? 2'h2 : 2'h1);
        end
    end

    // -------------------------------------------------------------------
    // Command transfer into the base domain
    // -------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmd_ff <= CMD_RESET;
        end
        else if (state_ff == SS_RUN && !strobe_stopped)
        begin
            cmd_ff.valid       <= 1'b1;
            cmd_ff.quad        <= quad_mode;
            cmd_ff.first_word  <= ring[rd_ptr_ff];
            cmd_ff.second_word <= quad_mode ? ring[rd_ptr_ff + 2'h1] : '0;
        end
        else
        begin
            cmd_ff <= CMD_RESET;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            locked_ff <= 1'b0;
        end
        else
        begin
            locked_ff <= (nxt_state == SS_RUN);
        end
    end

    // -------------------------------------------------------------------
    // Main bus phase markers
    // -------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ad_t1_ff <= 1'b0;
            ad_t2_ff <= 1'b0;
        end
        else
        begin
            ad_t1_ff <= !ready_n_sync;
            ad_t2_ff <= ad_t1_ff;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign cmd_out                  = cmd_ff;
    assign sync_locked              = locked_ff;
    assign stop_short_err           = stop_err_ff;
    assign ad_first_transfer_clock  = ad_t1_ff;
    assign ad_second_transfer_clock = ad_t2_ff;

endmodule : sps_sideband_port_sync

// ---- src/sps_pkg.sv ----
// Shared constants, types and helpers of the sideband port synchronizer.
// Assumes one base clock domain and one sideband strobe domain.
package sps_pkg;

    // -------------------------------------------------------------------
    // Pattern and timing counts
    // -------------------------------------------------------------------
    localparam logic [7:0] SYNC_PATTERN     = 8'hFE;
    localparam int         SYNC_TO_T1_CLKS  = 2;
    localparam logic [1:0] WAIT_LOAD        = 2'(SYNC_TO_T1_CLKS - 1);
    localparam logic [2:0] STOP_DETECT_CLKS = 3'h4;
    localparam logic [3:0] STOP_MIN_CLKS    = 4'h8;
    localparam logic [3:0] STOP_CNT_RESET   = 4'h0;
    localparam logic       READY_N_IDLE     = 1'b1;

    // -------------------------------------------------------------------
    // Ring of strobe-domain words
    // -------------------------------------------------------------------
    localparam int         RING_DEPTH = 4;
    localparam int         PTR_W      = 2;
    localparam int         WORD_W     = 16;
    localparam logic [1:0] PTR_RESET  = 2'h0;

    typedef logic [WORD_W-1:0]                 sps_word_t;
    typedef logic [RING_DEPTH-1:0][WORD_W-1:0] sps_ring_t;

    // -------------------------------------------------------------------
    // Lock state and command output
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SS_UNLOCKED = 2'b00,
        SS_WAIT     = 2'b01,
        SS_RUN      = 2'b10
    } sps_state_t;

    typedef struct packed {
        logic      valid;
        logic      quad;
        sps_word_t first_word;
        sps_word_t second_word;
    } sps_cmd_t;

    localparam sps_cmd_t CMD_RESET = '0;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic is_sync_pattern(input logic [7:0] lines);
        return lines == SYNC_PATTERN;
    endfunction : is_sync_pattern

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction : gray2bin

endpackage : sps_pkg

// ---- src/sps_sync2.sv ----
// Two flip-flop level synchronizer of parameterised width.
// Assumes the input changes at most one bit at a time when wider than one.
`timescale 1ns/100ps
module sps_sync2
    import sps_pkg::*;
#(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;

    // -------------------------------------------------------------------
    // Two stages; the first is read only by the second.
    // -------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_ff <= RESET_VAL;
            hold_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= async_in;
            hold_ff <= meta_ff;
        end
    end

    assign sync_out = hold_ff;

endmodule : sps_sync2

// ---- src/sps_strobe_capture.sv ----
// Strobe-domain capture of the sideband lines into a ring of words.
// Assumes the strobe is idle whenever the base-domain reset is released.
`timescale 1ns/100ps
module sps_strobe_capture
    import sps_pkg::*;
(
    // Strobe clock and reset
    input  wire logic             strobe_clk,
    input  wire logic             srst,
    // Sideband lines
    input  wire logic [7:0]       sideband_address_lines,
    // Ring towards the base domain
    output sps_ring_t             ring,
    output logic      [PTR_W-1:0] wr_gray
);

    logic      [7:0]       first_half_ff;
    sps_ring_t             ring_ff;
    logic      [PTR_W-1:0] wr_ptr_ff;
    logic      [PTR_W-1:0] wr_gray_ff;

    // -------------------------------------------------------------------
    // First half on the falling edge.
    // -------------------------------------------------------------------
    always_ff @(negedge strobe_clk)
    begin
        first_half_ff <= sideband_address_lines;
    end

    // -------------------------------------------------------------------
    // Second half on the rising edge completes a word.
    // -------------------------------------------------------------------
    always_ff @(posedge strobe_clk)
    begin
        ring_ff[wr_ptr_ff] <= {first_half_ff, sideband_address_lines};
    end

    // -------------------------------------------------------------------
    // Write pointer, cleared asynchronously whenever srst is high, strobe running or not.
    // -------------------------------------------------------------------
    always_ff @(posedge strobe_clk or posedge srst)
    begin
        if (srst)
        begin
            wr_ptr_ff  <= PTR_RESET;
            wr_gray_ff <= PTR_RESET;
        end
        else
        begin
            wr_ptr_ff  <= wr_ptr_ff + 2'h1;
            wr_gray_ff <= bin2gray(wr_ptr_ff + 2'h1);
        end
    end

    assign ring    = ring_ff;
    assign wr_gray = wr_gray_ff;

endmodule : sps_strobe_capture

// ---- verification/sps_sideband_port_sync_monitor.sv ----
// Checker of the sideband port synchronizer, watching its top ports only.
// Assumes it is bound to sps_sideband_port_sync and sees the base clock.
`timescale 1ns/100ps
module sps_sideband_port_sync_monitor
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Sideband, mode and handshake inputs
    input wire logic       sideband_strobe,
    input wire logic [7:0] sideband_address_lines,
    input wire logic       quad_mode,
    input wire logic       transfer_ready_handshake_n,
    // Outputs under watch
    input wire sps_cmd_t   cmd_out,
    input wire logic       sync_locked,
    input wire logic       stop_short_err,
    input wire logic       ad_first_transfer_clock,
    input wire logic       ad_second_transfer_clock
);
    // ------------------------------------------------------------
    // Helper logic and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic [3:0] idle_cnt_ff;
    // Counts base clocks for which the strobe has been seen high in a row.
    always_ff @(posedge clk)
        if (srst || !sideband_strobe)
            idle_cnt_ff <= 4'h0;
        else if (idle_cnt_ff != 4'hF)
            idle_cnt_ff <= idle_cnt_ff + 4'h1;
    sequence seq_sync_seen;
        !sync_locked && sideband_address_lines == SYNC_PATTERN;
    endsequence
    sequence seq_lock_up;
        !sync_locked ##1 sync_locked;
    endsequence
    sequence seq_first_mark;
        $rose(ad_first_transfer_clock) ##1 ad_second_transfer_clock;
    endsequence
    AST_QUIET_AFTER_RESET: assert property ($fell(srst) |->
        (cmd_out == CMD_RESET && !sync_locked && !stop_short_err && !ad_first_transfer_clock)
        ##1 !ad_first_transfer_clock)
        else $error("Outputs not clear after reset");
    AST_LOCK_AFTER_SYNC: assert property (seq_sync_seen |-> ##4 seq_lock_up)
        else $error("Lock not five clocks after sync pattern");
    AST_FIRST_CMD: assert property ($rose(sync_locked) |-> !cmd_out.valid ##1 cmd_out.valid)
        else $error("First command not one clock after lock");
    AST_NO_CMD_UNLOCKED: assert property (!sync_locked && !$past(sync_locked) |->
        !cmd_out.valid)
        else $error("Command while unlocked");
    AST_CMD_EVERY_CLOCK: assert property (sync_locked && $past(sync_locked) |->
        cmd_out.valid)
        else $error("Command missing while locked");
    AST_MODE_WIDTH: assert property (cmd_out.valid |-> cmd_out.quad == quad_mode &&
        (quad_mode || cmd_out.second_word == '0))
        else $error("Command width does not match mode");
    AST_UNLOCK_ON_STOP: assert property (idle_cnt_ff >= 4'hC |-> !sync_locked)
        else $error("Lock kept after strobe stopped");
    AST_ERR_AT_SYNC_ONLY: assert property (sync_locked && $past(sync_locked) |->
        $stable(stop_short_err))
        else $error("Stop flag changed while running");
    AST_READY_PHASE: assert property ($fell(transfer_ready_handshake_n) |->
        ##[2:4] seq_first_mark)
        else $error("Transfer clock marks late or out of order");
endmodule : sps_sideband_port_sync_monitor

bind sps_sideband_port_sync sps_sideband_port_sync_monitor u_monitor (
    .clk(clk), .srst(srst), .sideband_strobe(sideband_strobe),
    .sideband_address_lines(sideband_address_lines), .quad_mode(quad_mode),
    .transfer_ready_handshake_n(transfer_ready_handshake_n), .cmd_out(cmd_out),
    .sync_locked(sync_locked), .stop_short_err(stop_short_err),
    .ad_first_transfer_clock(ad_first_transfer_clock),
    .ad_second_transfer_clock(ad_second_transfer_clock)
);

// ---- verification/sps_master_model.sv ----
// Behavioural master driving the sideband strobe and sideband lines.
// Assumes it shares the base clock with the target.
`timescale 1ns/100ps
module sps_master_model
    import sps_pkg::*;
#(
    parameter logic [15:0] NOP_WORD = 16'h0000
)(
    // Base clock
    input  wire logic       clk,
    // Sideband pins
    output logic            sideband_strobe,
    output logic      [7:0] sideband_address_lines
);
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    logic busy;
    initial
    begin
        busy = 1'b0;
        sideband_strobe = 1'b1;
        sideband_address_lines = 8'h5A;
    end
    // Lines left alone change every clock and never form the sync pattern.
    always @(posedge clk)
        if (!busy)
            sideband_address_lines <= ~sideband_address_lines;
    task automatic frame(input sps_word_t words[$], input bit quad, input bit with_sync);
        busy = 1'b1;
        repeat (quad ? 8 : 4) words.push_back(NOP_WORD);
        @(posedge clk);
        if (with_sync)
            sideband_address_lines <= SYNC_PATTERN;
        @(posedge clk);
        sideband_address_lines <= 8'h5A;
        repeat (SYNC_TO_T1_CLKS) @(posedge clk);
        foreach (words[i])
        begin
            #3 sideband_address_lines = words[i][15:8];
            #3 sideband_strobe = 1'b0;
            #3 sideband_address_lines = words[i][7:0];
            #3 sideband_strobe = 1'b1;
        end
        busy = 1'b0;
    endtask : frame
endmodule : sps_master_model

// ---- verification/tb.sv ----
// Self-checking bench of the sideband port synchronizer.
// Assumes the master model drives the sideband pins and the checker is bound.
`timescale 1ns/100ps
module tb;
    import sps_pkg::*;
    // ------------------------------------------------------------
    // Signals, instances and scenarios
    // ------------------------------------------------------------
    logic       clk;
    logic       srst;
    logic       quad_mode;
    logic       transfer_ready_handshake_n;
    logic       sideband_strobe;
    logic [7:0] sideband_address_lines;
    sps_cmd_t   cmd_out;
    logic       sync_locked;
    logic       stop_short_err;
    logic       ad_first_transfer_clock;
    logic       ad_second_transfer_clock;
    int         fails;
    int         check_count;
    sps_cmd_t   got[$];
    int         gap;
    sps_word_t  words[$] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDE01};
    sps_sideband_port_sync DUT (
        .clk(clk), .srst(srst), .sideband_strobe(sideband_strobe),
        .sideband_address_lines(sideband_address_lines), .quad_mode(quad_mode),
        .transfer_ready_handshake_n(transfer_ready_handshake_n), .cmd_out(cmd_out),
        .sync_locked(sync_locked), .stop_short_err(stop_short_err),
        .ad_first_transfer_clock(ad_first_transfer_clock),
        .ad_second_transfer_clock(ad_second_transfer_clock)
    );
    sps_master_model master (
        .clk(clk), .sideband_strobe(sideband_strobe),
        .sideband_address_lines(sideband_address_lines)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Runs one frame and collects commands until the lock drops again.
    task automatic run_frame(input bit quad, input bit with_sync);
        int n;
        int lock_at;
        bit seen;
        lock_at = -1;
        gap = -1;
        seen = 1'b0;
        got = {};
        @(posedge clk);
        quad_mode <= quad;
        fork
            master.frame(words, quad, with_sync);
            for (n = 0; n < 60 && !(seen && sync_locked === 1'b0); n++)
            begin
                @(posedge clk);
                #1;
                if (sync_locked === 1'b1 && lock_at < 0)
                    lock_at = n;
                if (cmd_out.valid === 1'b1)
                begin
                    if (!seen)
                        gap = n - lock_at;
                    seen = 1'b1;
                    got.push_back(cmd_out);
                end
            end
        join
        chk("lock after stop", 34'(0), 34'(sync_locked));
        if (with_sync && n == 60)
        begin
            fails++;
            $display("BAD frame end expected unlock seen timeout");
            summarize();
        end
    endtask : run_frame
    task automatic test_idle;
        repeat (10) @(posedge clk);
        #1;
        chk("idle command", CMD_RESET, cmd_out);
    endtask : test_idle
    task automatic test_no_sync;
        run_frame(1'b0, 1'b0);
        chk("commands without sync", 34'(0), 34'(got.size()));
    endtask : test_no_sync
    task automatic test_reset_mid;
        repeat (12) @(posedge clk);
        fork
            master.frame(words, 1'b0, 1'b1);
            begin
                repeat (8) @(posedge clk);
                #1;
                chk("lock before reset", 34'(1), 34'(sync_locked));
                @(posedge clk);
                srst <= 1'b1;
            end
        join
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("command after reset", CMD_RESET, cmd_out);
    endtask : test_reset_mid
    task automatic test_double_rate;
        repeat (12) @(posedge clk);
        run_frame(1'b0, 1'b1);
        chk("first command delay", 34'(1), 34'(gap));
        for (int i = 0; i < 4; i++)
            chk("double rate word", {2'b10, words[i], 16'h0000}, got[i]);
        chk("stop flag", 34'(0), 34'(stop_short_err));
    endtask : test_double_rate
    task automatic test_short_stop;
        repeat (12) @(posedge clk);
        master.frame(words, 1'b0, 1'b1);
        repeat (6) @(posedge clk);
        run_frame(1'b0, 1'b1);
        chk("short stop flag", 34'(1), 34'(stop_short_err));
    endtask : test_short_stop
    task automatic test_quad_rate;
        repeat (12) @(posedge clk);
        run_frame(1'b1, 1'b1);
        chk("quad rate pair", {2'b11, words[0], words[1]}, got[0]);
        chk("stop flag cleared", 34'(0), 34'(stop_short_err));
    endtask : test_quad_rate
    task automatic test_ready;
        int hi1;
        int hi2;
        hi1 = 0;
        hi2 = 0;
        repeat (2)
            for (int k = 0; k < 14; k++)
            begin
                @(posedge clk);
                transfer_ready_handshake_n <= (k >= 3);
                #1;
                hi1 += (ad_first_transfer_clock === 1'b1);
                hi2 += (ad_second_transfer_clock === 1'b1);
            end
        chk("first clock marks", 34'(6), 34'(hi1));
        chk("second clock marks", 34'(6), 34'(hi2));
    endtask : test_ready
    initial
    begin
        srst = 1'b1;
        quad_mode = 1'b0;
        transfer_ready_handshake_n = 1'b1;
        fails = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        test_idle();
        test_no_sync();
        test_reset_mid();
        test_double_rate();
        test_short_stop();
        test_quad_rate();
        test_ready();
        summarize();
    end
endmodule : tb
